//--- include/cld_pkg.sv
// config lock and io decode: shared constants, carriers and helpers
// assumes one clock domain and a byte-wide register port from the lpc front end
// Summary of operation
// - disabled legacy module with float bit floats pins
// - all sixteen address bits above the offset compared on decode, except keyboard bit two and parallel bit ten
// - low address bits give offset within range
// - base offset bits read zero, base aligned
// - legacy base bits fifteen to eleven forced zero
// - parallel port base limited to 3F8h
// - non-legacy devices decode full sixteen-bit space
// - keyboard uses bit two, parallel bit ten
// - set lock freezes itself and its group
// - locks cleared only by power-up reset
// - pin mux lock guards wait bit, cfg2-4
// - gpio cfg lock guards cfg, route, mode
// - fast disable lock guards fd bits, global enable
// - clock lock freezes whole clock register
// - port lock guards port cfg and data bits
// - health lock freezes whole health register
// - wake lock guards led, wake, ps2 registers
// - split register reads one, writes another
// - write-only bits read back zero
// - any write clears write-any-to-clear bit
// - writing one clears, zero leaves unchanged
// - writing one sets, zero leaves unchanged
// - enabled needs activate, global enable, and fast disable clear on devices 0-4 only
package cld_pkg;
  localparam int CLD_NDEV = 8;
  localparam int CLD_NLEG = 6;
  localparam int CLD_NPORT = 8;
  localparam int CLD_NKEY = 8;
  localparam int CLD_LEG_W = 8;
  // ----------------------------------------------------------------
  // logical devices; 0..5 legacy
  // ----------------------------------------------------------------
  localparam int CLD_LD_FLOPPY = 0;
  localparam int CLD_LD_PAR = 1;
  localparam int CLD_LD_KBD = 5;
  localparam int CLD_LD_HEALTH = 6;
  localparam int CLD_LD_GPIO = 7;
  localparam int CLD_NO_BIT = 16;
  // offset width per device (2**n byte range)
  localparam int CLD_SZ_LEG = 3;
  localparam int CLD_SZ_KBD = 0;
  localparam int CLD_SZ_HEALTH = 4;
  localparam int CLD_SZ_GPIO = 5;
  localparam int CLD_KBD_BIT = 2;
  localparam int CLD_PAR_BIT = 10;
  // writable base bits: alignment, legacy ceiling 7FXh, parallel ceiling 3F8h
  localparam logic [15:0] CLD_WM_LEG = 16'h07F8;
  localparam logic [15:0] CLD_WM_PAR = 16'h03F8;
  localparam logic [15:0] CLD_WM_KBD = 16'h07FB;
  localparam logic [15:0] CLD_WM_HEALTH = 16'hFFF0;
  localparam logic [15:0] CLD_WM_GPIO = 16'hFFE0;
  localparam logic [15:0] CLD_CFG_BASE = 16'h002E;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CLD_A_CFG1 = 8'h00;
  localparam logic [7:0] CLD_A_CFG2 = 8'h01;
  localparam logic [7:0] CLD_A_CFG3 = 8'h02;
  localparam logic [7:0] CLD_A_CFG4 = 8'h03;
  localparam logic [7:0] CLD_A_FDIS = 8'h04;
  localparam logic [7:0] CLD_A_CLK = 8'h05;
  localparam logic [7:0] CLD_A_HM = 8'h06;
  localparam logic [7:0] CLD_A_WAKE = 8'h07;
  localparam logic [7:0] CLD_A_SLED = 8'h08;
  localparam logic [7:0] CLD_A_WREG = 8'h09;
  localparam logic [7:0] CLD_A_KEY = 8'h10;
  localparam logic [7:0] CLD_A_PSEL = 8'h20;
  localparam logic [7:0] CLD_A_GCFGA = 8'h21;
  localparam logic [7:0] CLD_A_GCFGB = 8'h22;
  localparam logic [7:0] CLD_A_GEVR = 8'h23;
  localparam logic [7:0] CLD_A_GMODE = 8'h24;
  localparam logic [7:0] CLD_A_GDO = 8'h25;
  localparam logic [7:0] CLD_A_GDIO = 8'h26;
  localparam logic [7:0] CLD_A_GEVT = 8'h27;
  localparam logic [7:0] CLD_A_DISEV = 8'h28;
  localparam logic [7:0] CLD_A_PULSE = 8'h29;
  localparam logic [2:0] CLD_A_LD_HI = 3'h2;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CLD_B_GLOBAL_MODULE_ENABLE = 0;
  localparam int CLD_B_MUXLK = 1;
  localparam int CLD_B_GCFLK = 2;
  localparam int CLD_B_IO_WAIT_STATE_SEL = 3;
  localparam int CLD_B_FDLK = 5;
  localparam int CLD_B_TOPLK = 7;
  localparam int CLD_B_PLOCK = 3;
  localparam logic [7:0] CLD_FD_MASK = 8'h0F;
  localparam logic [7:0] CLD_FD_SCRATCH = 8'hC0;
  localparam logic [7:0] CLD_SLED_LKM = 8'h07;
  localparam logic [7:0] CLD_PORT_LKM = 8'h1F;
  localparam logic [7:0] CLD_CFG1_RST = 8'h01;
  localparam int CLD_NWREG = 5;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cld_regbus_t;

  typedef struct packed {
    logic [15:0] addr;
    logic valid;
  } cld_io_req_t;

  typedef struct packed {
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic [7:0] clk_cfg;
    logic [7:0] hm_cfg;
    logic [7:0] wake_ctl;
    logic [7:0] sled;
    logic io_wait;
  } cld_ctl_t;

  function automatic logic [7:0] cld_upd(input logic [7:0] old, input logic [7:0] wd,
                                        input logic [7:0] wm);
    return (old & ~wm) | (wd & wm);
  endfunction

  // fast disable bit that applies to a logical device; keyboard and non-legacy have none
  function automatic int cld_fd_bit(input int ld);
    return (ld < 4) ? ld : ((ld == 4) ? 3 : -1);
  endfunction
endpackage

//--- logic/cld_io_match.sv
// one logical device's runtime range decoder
// assumes base arrives already masked to its writable bits
`timescale 1ns/100ps
module cld_io_match #(
  parameter int SZ = 3,
  parameter int IGN = 16
) (
  input wire logic [15:0] base, // device base address
  input wire logic enabled, // device enabled
  input wire logic [15:0] io_addr, // host io address
  output logic hit, // address inside range
  output logic [4:0] off, // register offset
  output logic ext // extra internal decode bit
);
  import cld_pkg::*;
  localparam logic [16:0] SPAN = 17'(1) << SZ;
  localparam logic [15:0] IGNM = (IGN < 16) ? (16'(1) << IGN) : 16'h0000;
  localparam logic [15:0] OFFM = SPAN[15:0] - 16'h0001;
  localparam logic [15:0] CMPM = ~(OFFM | IGNM);
  logic [15:0] offs;

  always_comb begin
    hit = enabled && ((io_addr & CMPM) == (base & CMPM));
    offs = io_addr & OFFM;
    off = offs[4:0];
    ext = (IGN < 16) ? |(io_addr & IGNM) : 1'b0;
  end
endmodule

//--- logic/cld_float_ctl.sv
// pin floating for one legacy module
// assumes pad inputs come from pins outside the clock domain
`timescale 1ns/100ps
module cld_float_ctl (
  input wire logic clk, // core clock
  input wire logic arst_n, // async reset
  input wire logic float_req, // float bit set and module disabled
  input wire logic [cld_pkg::CLD_LEG_W-1:0] mod_out, // module output data
  input wire logic [cld_pkg::CLD_LEG_W-1:0] mod_oe, // module output enables
  input wire logic [cld_pkg::CLD_LEG_W-1:0] pad_in, // pin levels
  output logic [cld_pkg::CLD_LEG_W-1:0] pad_out, // pin drive value
  output logic [cld_pkg::CLD_LEG_W-1:0] pad_oe, // pin drive enable
  output logic [cld_pkg::CLD_LEG_W-1:0] mod_in // synchronised input to module
);
  import cld_pkg::*;
  typedef struct packed {
    logic [CLD_LEG_W-1:0] s1;
    logic [CLD_LEG_W-1:0] s2;
  } cld_flt_st_t;
  cld_flt_st_t st, next_st;

  always_comb begin
    next_st.s1 = pad_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // a floated module sees constant zero so stray pin levels cannot wake it
  always_comb begin
    pad_out = float_req ? '0 : mod_out;
    pad_oe = float_req ? '0 : mod_oe;
    mod_in = float_req ? '0 : st.s2;
  end
endmodule

//--- logic/cld_top.sv
// config lock and io decode: register bank, lock groups, range decode, float
// assumes a byte register port and io requests on the same clock as clk
`timescale 1ns/100ps
module cld_top (
  input wire logic clk, // 125 MHz core clock
  input wire logic arst_n, // power-up reset, async
  input wire cld_pkg::cld_regbus_t bus, // register access
  output logic [7:0] rdata, // read data, cycle after rd
  input wire cld_pkg::cld_io_req_t io, // host io cycle address
  output logic cfg_hit, // config index/data pair hit
  output logic [cld_pkg::CLD_NDEV-1:0] io_sel, // device range hit
  output logic [4:0] io_off, // offset in range
  output logic io_ext, // keyboard bit2 / parallel bit10
  output logic [cld_pkg::CLD_NDEV-1:0] mod_en, // module enabled
  output cld_pkg::cld_ctl_t ctl, // configuration out
  output logic [7:0] sw_pulse, // write-only command pulse
  input wire logic [cld_pkg::CLD_NPORT-1:0] gpio_in, // gpio pin levels
  output logic [cld_pkg::CLD_NPORT-1:0] gpio_out, // gpio pin drive
  output logic [cld_pkg::CLD_NPORT-1:0] gpio_oe, // gpio drive enable
  output logic [cld_pkg::CLD_NPORT-1:0] gpio_aux, // second data output
  input wire logic [cld_pkg::CLD_NLEG-1:0][cld_pkg::CLD_LEG_W-1:0] leg_out, // module out
  input wire logic [cld_pkg::CLD_NLEG-1:0][cld_pkg::CLD_LEG_W-1:0] leg_oe, // module oe
  input wire logic [cld_pkg::CLD_NLEG-1:0][cld_pkg::CLD_LEG_W-1:0] leg_pad_in, // pins
  output logic [cld_pkg::CLD_NLEG-1:0][cld_pkg::CLD_LEG_W-1:0] leg_pad_out, // pin value
  output logic [cld_pkg::CLD_NLEG-1:0][cld_pkg::CLD_LEG_W-1:0] leg_pad_oe, // pin enable
  output logic [cld_pkg::CLD_NLEG-1:0][cld_pkg::CLD_LEG_W-1:0] leg_in // to module
);
  import cld_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic [7:0] fdis;
    logic [7:0] clk_cfg;
    logic [7:0] hm_cfg;
    logic [7:0] wake_ctl;
    logic [7:0] sled;
    logic [CLD_NWREG-1:0][7:0] wreg;
    logic [CLD_NKEY-1:0][7:0] key;
    logic [2:0] psel;
    logic [CLD_NPORT-1:0][7:0] cfg_a;
    logic [CLD_NPORT-1:0][7:0] cfg_b;
    logic [CLD_NPORT-1:0][7:0] evr;
    logic [CLD_NPORT-1:0][7:0] mode;
    logic [CLD_NPORT-1:0] dout;
    logic [CLD_NPORT-1:0] dio;
    logic [CLD_NPORT-1:0] evt;
    logic [7:0] disev;
    logic [7:0] pulse;
    logic [CLD_NDEV-1:0] act;
    logic [CLD_NDEV-1:0] flt;
    logic [CLD_NDEV-1:0][15:0] base;
    logic [CLD_NDEV-1:0] en_q;
    logic [CLD_NPORT-1:0] gs1;
    logic [CLD_NPORT-1:0] gs2;
    logic [CLD_NPORT-1:0] gprev;
    logic [7:0] rdata;
    logic [CLD_NDEV-1:0] io_sel;
    logic [4:0] io_off;
    logic io_ext;
    logic cfg_hit;
  } cld_state_t;

  cld_state_t st, next_st;
  logic [CLD_NDEV-1:0] en;
  logic [CLD_NDEV-1:0] hit;
  logic [CLD_NDEV-1:0][4:0] off;
  logic [CLD_NDEV-1:0] ext;
  logic mux_lk, gcf_lk, fd_lk, clk_lk, hm_lk, wk_lk;

  // writable bits of each base register
  function automatic logic [15:0] base_wm(input int ld);
    if (ld == CLD_LD_PAR) begin
      return CLD_WM_PAR;
    end else if (ld == CLD_LD_KBD) begin
      return CLD_WM_KBD;
    end else if (ld == CLD_LD_HEALTH) begin
      return CLD_WM_HEALTH;
    end else if (ld == CLD_LD_GPIO) begin
      return CLD_WM_GPIO;
    end else begin
      return CLD_WM_LEG;
    end
  endfunction

  // ----------------------------------------------------------------
  // lock and enable terms
  // ----------------------------------------------------------------
  always_comb begin
    mux_lk = st.cfg1[CLD_B_MUXLK];
    gcf_lk = st.cfg1[CLD_B_GCFLK];
    fd_lk = st.fdis[CLD_B_FDLK];
    clk_lk = st.clk_cfg[CLD_B_TOPLK];
    hm_lk = st.hm_cfg[CLD_B_TOPLK];
    wk_lk = st.wake_ctl[CLD_B_TOPLK];
    for (int i = 0; i < CLD_NDEV; i++) begin
      en[i] = st.act[i] && st.cfg1[CLD_B_GLOBAL_MODULE_ENABLE];
      if (cld_fd_bit(i) >= 0) begin
        en[i] = en[i] && !st.fdis[3'(cld_fd_bit(i))];
      end
    end
  end

  // ----------------------------------------------------------------
  // range decoders and pin float
  // ----------------------------------------------------------------
  for (genvar g = 0; g < CLD_NDEV; g++) begin : g_match
    localparam int SZ = (g == CLD_LD_KBD) ? CLD_SZ_KBD :
                        (g == CLD_LD_HEALTH) ? CLD_SZ_HEALTH :
                        (g == CLD_LD_GPIO) ? CLD_SZ_GPIO : CLD_SZ_LEG;
    localparam int IGN = (g == CLD_LD_KBD) ? CLD_KBD_BIT :
                         (g == CLD_LD_PAR) ? CLD_PAR_BIT : CLD_NO_BIT;
    cld_io_match #(.SZ(SZ), .IGN(IGN)) u_match (
      .base(st.base[g]),
      .enabled(en[g]),
      .io_addr(io.addr),
      .hit(hit[g]),
      .off(off[g]),
      .ext(ext[g])
    );
  end

  for (genvar g = 0; g < CLD_NLEG; g++) begin : g_float
    cld_float_ctl u_float (
      .clk(clk),
      .arst_n(arst_n),
      .float_req(st.flt[g] && !st.en_q[g]),
      .mod_out(leg_out[g]),
      .mod_oe(leg_oe[g]),
      .pad_in(leg_pad_in[g]),
      .pad_out(leg_pad_out[g]),
      .pad_oe(leg_pad_oe[g]),
      .mod_in(leg_in[g])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] a;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [7:0] wm;
    logic [2:0] p;
    logic [2:0] ld;
    logic [15:0] bnew;
    logic [CLD_NPORT-1:0] rise;
    logic [CLD_NPORT-1:0] plk;
    a = bus.addr;
    wd = bus.wdata;
    rd = 8'h00;
    wm = 8'h00;
    p = st.psel;
    ld = a[4:2];
    bnew = st.base[ld];
    next_st = st;
    for (int i = 0; i < CLD_NPORT; i++) begin
      plk[i] = st.cfg_a[i][CLD_B_PLOCK];
    end
    next_st.gs1 = gpio_in;
    next_st.gs2 = st.gs1;
    next_st.gprev = st.gs2;
    rise = st.gs2 & ~st.gprev;
    next_st.en_q = en;
    next_st.pulse = 8'h00;
    // a module dropping out of the enabled set raises the disable event
    if (|(st.en_q & ~en)) begin
      next_st.disev[0] = 1'b1;
    end
    // runtime decode; config pair compared on all bits but the index/data select
    next_st.cfg_hit = io.valid && (io.addr[15:1] == CLD_CFG_BASE[15:1]);
    next_st.io_sel = io.valid ? hit : '0;
    next_st.io_off = 5'h00;
    next_st.io_ext = 1'b0;
    for (int i = 0; i < CLD_NDEV; i++) begin
      if (io.valid && hit[i]) begin
        next_st.io_off = next_st.io_off | off[i];
        next_st.io_ext = next_st.io_ext | ext[i];
      end
    end

    // writes: each lock removes its group from the write mask; the cycle still completes
    if (bus.wr) begin
      if (a == CLD_A_CFG1) begin
        wm = 8'hF0;
        if (!mux_lk) begin
          wm[CLD_B_IO_WAIT_STATE_SEL] = 1'b1;
        end
        if (!fd_lk) begin
          wm[CLD_B_GLOBAL_MODULE_ENABLE] = 1'b1;
        end
        next_st.cfg1 = cld_upd(st.cfg1, wd, wm);
        if (!mux_lk) begin
          next_st.cfg1[CLD_B_MUXLK] = st.cfg1[CLD_B_MUXLK] | wd[CLD_B_MUXLK];
        end
        if (!gcf_lk) begin
          next_st.cfg1[CLD_B_GCFLK] = st.cfg1[CLD_B_GCFLK] | wd[CLD_B_GCFLK];
        end
      end else if (a == CLD_A_CFG2 && !mux_lk) begin
        next_st.cfg2 = wd;
      end else if (a == CLD_A_CFG3 && !mux_lk) begin
        next_st.cfg3 = wd;
      end else if (a == CLD_A_CFG4 && !mux_lk) begin
        next_st.cfg4 = wd;
      end else if (a == CLD_A_FDIS) begin
        wm = fd_lk ? CLD_FD_SCRATCH : (CLD_FD_SCRATCH | CLD_FD_MASK);
        next_st.fdis = cld_upd(st.fdis, wd, wm);
        next_st.fdis[CLD_B_FDLK] = st.fdis[CLD_B_FDLK] | wd[CLD_B_FDLK];
      end else if (a == CLD_A_CLK && !clk_lk) begin
        next_st.clk_cfg = wd;
      end else if (a == CLD_A_HM && !hm_lk) begin
        next_st.hm_cfg = wd;
      end else if (a == CLD_A_WAKE && !wk_lk) begin
        next_st.wake_ctl = wd;
      end else if (a == CLD_A_SLED) begin
        wm = wk_lk ? ~CLD_SLED_LKM : 8'hFF;
        next_st.sled = cld_upd(st.sled, wd, wm);
      end else if (a >= CLD_A_WREG && a < CLD_A_WREG + 8'(CLD_NWREG)) begin
        if (!wk_lk) begin
          next_st.wreg[3'(a - CLD_A_WREG)] = wd;
        end
      end else if (a >= CLD_A_KEY && a < CLD_A_KEY + 8'(CLD_NKEY)) begin
        if (!wk_lk) begin
          next_st.key[a[2:0]] = wd;
        end
      end else if (a == CLD_A_PSEL) begin
        next_st.psel = wd[2:0];
      end else if (a == CLD_A_GCFGA) begin
        wm = gcf_lk ? 8'h00 : ~CLD_PORT_LKM;
        if (!plk[p]) begin
          wm = wm | (gcf_lk ? 8'h00 : CLD_PORT_LKM);
          wm[CLD_B_PLOCK] = 1'b0;
        end
        next_st.cfg_a[p] = cld_upd(st.cfg_a[p], wd, wm);
        if (!plk[p]) begin
          next_st.cfg_a[p][CLD_B_PLOCK] = wd[CLD_B_PLOCK];
        end
      end else if (a == CLD_A_GCFGB && !gcf_lk && !plk[p]) begin
        next_st.cfg_b[p] = wd;
      end else if (a == CLD_A_GEVR && !gcf_lk) begin
        next_st.evr[p] = wd;
      end else if (a == CLD_A_GMODE && !gcf_lk) begin
        next_st.mode[p] = wd;
      end else if (a == CLD_A_GDO) begin
        next_st.dout = cld_upd(st.dout, wd, ~plk);
      end else if (a == CLD_A_GDIO) begin
        next_st.dio = cld_upd(st.dio, wd, ~plk);
      end else if (a == CLD_A_GEVT) begin
        next_st.evt = st.evt & ~wd;
      end else if (a == CLD_A_DISEV) begin
        next_st.disev = 8'h00;
      end else if (a == CLD_A_PULSE) begin
        next_st.pulse = wd;
      end else if (a[7:5] == CLD_A_LD_HI) begin
        if (a[1:0] == 2'h0) begin
          next_st.act[ld] = wd[0];
        end else if (a[1:0] == 2'h1) begin
          bnew[15:8] = wd;
        end else if (a[1:0] == 2'h2) begin
          bnew[7:0] = wd;
        end else begin
          next_st.flt[ld] = wd[0] && (ld < 3'(CLD_NLEG));
        end
        next_st.base[ld] = bnew & base_wm(int'(ld));
      end
    end
    // hardware sets win over a same-cycle host clear
    next_st.evt = next_st.evt | rise;
    if (|(st.en_q & ~en)) begin
      next_st.disev[0] = 1'b1;
    end

    // reads: registered, unmapped answers zero
    if (a == CLD_A_CFG1) begin
      rd = st.cfg1;
    end else if (a == CLD_A_CFG2) begin
      rd = st.cfg2;
    end else if (a == CLD_A_CFG3) begin
      rd = st.cfg3;
    end else if (a == CLD_A_CFG4) begin
      rd = st.cfg4;
    end else if (a == CLD_A_FDIS) begin
      rd = st.fdis;
    end else if (a == CLD_A_CLK) begin
      rd = st.clk_cfg;
    end else if (a == CLD_A_HM) begin
      rd = st.hm_cfg;
    end else if (a == CLD_A_WAKE) begin
      rd = st.wake_ctl;
    end else if (a == CLD_A_SLED) begin
      rd = st.sled;
    end else if (a >= CLD_A_WREG && a < CLD_A_WREG + 8'(CLD_NWREG)) begin
      rd = st.wreg[3'(a - CLD_A_WREG)];
    end else if (a >= CLD_A_KEY && a < CLD_A_KEY + 8'(CLD_NKEY)) begin
      rd = st.key[a[2:0]];
    end else if (a == CLD_A_PSEL) begin
      rd = {5'h00, st.psel};
    end else if (a == CLD_A_GCFGA) begin
      rd = st.cfg_a[p];
    end else if (a == CLD_A_GCFGB) begin
      rd = st.cfg_b[p];
    end else if (a == CLD_A_GEVR) begin
      rd = st.evr[p];
    end else if (a == CLD_A_GMODE) begin
      rd = st.mode[p];
    end else if (a == CLD_A_GDO) begin
      rd = st.dout;
    end else if (a == CLD_A_GDIO) begin
      rd = st.gs2;
    end else if (a == CLD_A_GEVT) begin
      rd = st.evt;
    end else if (a == CLD_A_DISEV) begin
      rd = st.disev;
    end else if (a == CLD_A_PULSE) begin
      rd = 8'h00;
    end else if (a[7:5] == CLD_A_LD_HI) begin
      if (a[1:0] == 2'h0) begin
        rd = {7'h00, st.act[ld]};
      end else if (a[1:0] == 2'h1) begin
        rd = st.base[ld][15:8];
      end else if (a[1:0] == 2'h2) begin
        rd = st.base[ld][7:0];
      end else begin
        rd = {7'h00, st.flt[ld]};
      end
    end
    next_st.rdata = bus.rd ? rd : 8'h00;
  end

  // ----------------------------------------------------------------
  // registers; only power-up reset clears the locks
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.cfg1 <= CLD_CFG1_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    rdata = st.rdata;
    cfg_hit = st.cfg_hit;
    io_sel = st.io_sel;
    io_off = st.io_off;
    io_ext = st.io_ext;
    mod_en = st.en_q;
    sw_pulse = st.pulse;
    gpio_out = st.dio;
    gpio_aux = st.dout;
    for (int i = 0; i < CLD_NPORT; i++) begin
      gpio_oe[i] = st.cfg_a[i][0];
    end
    ctl.cfg2 = st.cfg2;
    ctl.cfg3 = st.cfg3;
    ctl.cfg4 = st.cfg4;
    ctl.clk_cfg = st.clk_cfg;
    ctl.hm_cfg = st.hm_cfg;
    ctl.wake_ctl = st.wake_ctl;
    ctl.sled = st.sled;
    ctl.io_wait = st.cfg1[CLD_B_IO_WAIT_STATE_SEL];
  end
endmodule

//--- verification/cld_lpc_host.sv
// lpc host model: turns one go request into one io cycle
// assumes go and addr change just after a rising clk edge
`timescale 1ns/100ps
module cld_lpc_host (
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire logic go, // start one io cycle
  input wire logic [15:0] addr, // io address
  output cld_pkg::cld_io_req_t io // io cycle to device
);
  import cld_pkg::*;
  // between cycles the address flips, so a stale value can never pass for a hit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io <= '0;
    end else if (go) begin
      io <= '{addr, 1'b1};
    end else begin
      io <= '{~io.addr, 1'b0};
    end
  end
endmodule

//--- verification/cld_asserts.sv
// checker for cld_top: lock groups, register port and io decode timing
// assumes it is bound onto cld_top; one clock, async low reset
`timescale 1ns/100ps
module cld_asserts (
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire cld_pkg::cld_regbus_t bus, // register port
  input wire logic [7:0] rdata, // read data
  input wire cld_pkg::cld_io_req_t io, // io cycle
  input wire logic cfg_hit, // config hit
  input wire logic [cld_pkg::CLD_NDEV-1:0] io_sel, // device hit
  input wire logic [4:0] io_off, // offset
  input wire logic io_ext, // extra decode bit
  input wire logic [cld_pkg::CLD_NDEV-1:0] mod_en, // enables
  input wire cld_pkg::cld_ctl_t ctl, // config out
  input wire logic [7:0] sw_pulse // command pulse
);
  import cld_pkg::*;
  logic cfg_req;
  assign cfg_req = io.valid && io.addr[15:1] == CLD_CFG_BASE[15:1];
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_WO_READ: assert property (bus.rd && bus.addr == CLD_A_PULSE |=> rdata == 8'h00)
    else $error("write-only read nonzero");
  AST_PULSE: assert property (bus.wr && bus.addr == CLD_A_PULSE |=> sw_pulse == $past(bus.wdata))
    else $error("pulse value wrong");
  AST_CLK_LOCK: assert property (ctl.clk_cfg[CLD_B_TOPLK] |=> $stable(ctl.clk_cfg))
    else $error("clock cfg moved while locked");
  AST_HM_LOCK: assert property (ctl.hm_cfg[CLD_B_TOPLK] |=> $stable(ctl.hm_cfg))
    else $error("health cfg moved while locked");
  AST_WAKE_LOCK: assert property (ctl.wake_ctl[7] |=> $stable(ctl.wake_ctl) && $stable(ctl.sled[2:0]))
    else $error("wake group moved while locked");
  AST_CFG_HIT: assert property (cfg_req |=> cfg_hit)
    else $error("config pair missed");
  AST_CFG_MISS: assert property (!cfg_req |=> !cfg_hit)
    else $error("config pair false hit");
  AST_SEL_EN: assert property ((io_sel & ~mod_en) == 8'h00 && $onehot0(io_sel))
    else $error("hit on disabled device");
  AST_GPIO_OFF: assert property (io_sel[CLD_LD_GPIO] |-> io_off == $past(io.addr[4:0]))
    else $error("gpio offset wrong");
  AST_KBD_EXT: assert property (io_sel[CLD_LD_KBD] |-> io_ext == $past(io.addr[2]))
    else $error("keyboard bit wrong");
  AST_LEG_CEIL: assert property (io_sel[CLD_LD_FLOPPY] |-> $past(io.addr[15:11]) == 5'h00)
    else $error("legacy hit above ceiling");
  cover property (io_sel[CLD_LD_GPIO]);
  cover property (cfg_hit);
  cover property (ctl.clk_cfg[7] && bus.wr && bus.addr == CLD_A_CLK);
endmodule

//--- verification/tb_config_lock_and_io_decode.sv
// bench for cld_top: registers, locks, io decode and pin floating
// assumes the lpc host model issues io cycles on request
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module tb_config_lock_and_io_decode;
  import cld_pkg::*;
  logic clk = 0, arst_n = 0, io_ext, cfg_hit, go = 0;
  cld_regbus_t bus = '0;
  cld_io_req_t io;
  cld_ctl_t ctl;
  logic [7:0] rdata, sw_pulse, io_sel, mod_en, gpio_out, gpio_oe, gpio_aux, gpio_in = 0;
  logic [4:0] io_off;
  logic [15:0] paddr = 0, b;
  logic [5:0][7:0] leg_out = '1, leg_oe = '1, leg_pad_in = '1, leg_pad_out, leg_pad_oe, leg_in;
  logic [31:0] rs = 32'hB31D;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  cld_top i_dut (.clk, .arst_n, .bus, .rdata, .io, .cfg_hit, .io_sel, .io_off, .io_ext, .mod_en,
    .ctl, .sw_pulse, .gpio_in, .gpio_out, .gpio_oe, .gpio_aux, .leg_out, .leg_oe, .leg_pad_in,
    .leg_pad_out, .leg_pad_oe, .leg_in);
  cld_lpc_host i_host (.clk, .arst_n, .go, .addr(paddr), .io);
  initial forever #4 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic probe(input logic [15:0] a, input logic [7:0] es, input logic [4:0] eo);
    @(posedge clk) paddr <= a;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    @(posedge clk) #1 `CHK(io_sel, es)
    if (es != 8'h00) `CHK(io_off, eo)
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // a hung handshake would otherwise stall the run forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd(CLD_A_CFG1, CLD_CFG1_RST);
    rd(CLD_A_CLK, 8'h00);
    rd(8'hFF, 8'h00);
    probe(CLD_CFG_BASE + 16'h0001, 8'h00, 5'h00);
    `CHK(cfg_hit, 1'b1)
    for (int k = 0; k < 2; k++) begin
      wr(8'(8'h41 + 4 * k), 8'hFF);
      wr(8'(8'h42 + 4 * k), 8'hFF);
      rd(8'(8'h41 + 4 * k), k ? 8'h03 : 8'h07);
      rd(8'(8'h42 + 4 * k), 8'hF8);
    end
    wr(8'h40, 8'h01);
    rs = xs(rs);
    probe(16'h07F8 | 16'(rs[2:0]), 8'h01, 5'(rs[2:0]));
    probe(16'hF7F8, 8'h00, 5'h00);
    wr(8'h56, 8'h60);
    wr(8'h54, 8'h01);
    probe(16'h0064, 8'h20, 5'h00);
    `CHK(io_ext, 1'b1)
    wr(8'h43, 8'h01);
    `CHK(leg_pad_oe[0], 8'hFF)
    wr(CLD_A_FDIS, 8'h01);
    repeat (2) @(posedge clk);
    #1 `CHK(mod_en[0], 1'b0)
    `CHK(leg_pad_oe[0], 8'h00)
    `CHK(leg_pad_out[0], 8'h00)
    `CHK(leg_in[0], 8'h00)
    probe(16'h07F8, 8'h00, 5'h00);
    wr(CLD_A_FDIS, 8'h00);
    rs = xs(rs);
    b = {1'b1, rs[14:0]} & CLD_WM_GPIO;
    wr(8'h5D, b[15:8]);
    wr(8'h5E, rs[7:0]);
    wr(8'h5C, 8'h01);
    rd(8'h5E, b[7:0]);
    probe(b | 16'(rs[20:16]), 8'h80, rs[20:16]);
    for (int k = 5; k < 8; k++) begin
      rs = xs(rs);
      wr(8'(k), {1'b1, rs[6:0]});
      wr(8'(k), 8'h00);
      rd(8'(k), {1'b1, rs[6:0]});
    end
    wr(CLD_A_SLED, 8'hFF);
    rd(CLD_A_SLED, 8'hF8);
    rs = xs(rs);
    wr(CLD_A_CFG2, rs[7:0]);
    wr(CLD_A_CFG1, 8'h03);
    wr(CLD_A_CFG2, ~rs[7:0]);
    rd(CLD_A_CFG2, rs[7:0]);
    wr(CLD_A_FDIS, 8'h20);
    wr(CLD_A_FDIS, 8'hC1);
    rd(CLD_A_FDIS, 8'hE0);
    wr(CLD_A_CFG1, 8'h08);
    rd(CLD_A_CFG1, 8'h03);
    rs = xs(rs);
    @(posedge clk) gpio_in <= rs[15:8];
    wr(CLD_A_PULSE, rs[7:0]);
    `CHK(sw_pulse, rs[7:0])
    rd(CLD_A_PULSE, 8'h00);
    wr(CLD_A_GDIO, rs[23:16]);
    `CHK(gpio_out, rs[23:16])
    rd(CLD_A_GDIO, rs[15:8]);
    rd(CLD_A_GEVT, rs[15:8]);
    wr(CLD_A_GEVT, 8'h0F);
    rd(CLD_A_GEVT, rs[15:8] & 8'hF0);
    rd(CLD_A_DISEV, 8'h01);
    wr(CLD_A_DISEV, 8'h00);
    rd(CLD_A_DISEV, 8'h00);
    wr(CLD_A_GCFGA, 8'h09);
    wr(CLD_A_GCFGA, 8'h00);
    rd(CLD_A_GCFGA, 8'h09);
    wr(CLD_A_GDO, 8'hFF);
    wr(CLD_A_GDIO, 8'h00);
    `CHK(gpio_out, 8'(rs[16]))
    `CHK(gpio_oe, 8'h01)
    `CHK(gpio_aux, 8'hFE)
    wr(CLD_A_CFG1, 8'h04);
    wr(CLD_A_GEVR, 8'hAA);
    rd(CLD_A_GEVR, 8'h00);
    close_out;
  end
endmodule
bind cld_top cld_asserts u_chk (.clk, .arst_n, .bus, .rdata, .io, .cfg_hit, .io_sel, .io_off,
  .io_ext, .mod_en, .ctl, .sw_pulse);
